// >>> gpib_block_talker_transmit.sv
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "gpib_xmit_consts.svh"

// Overview of operation
// - Send exactly the requested count, max 32767
// - Control bit 7 appends selected terminator
// - Control bits 6:5 select terminator definition
// - Defaults LF, CR LF, CR, LF CR
// - Terminator definitions are writable registers
// - Control bit 0 puts EOI on final byte
// - Control bits 4:1 are ignored
// - Status bit 3 flags handshake timeout
// - Status bit 1 flags not addressed talker
// - Status bit 8 flags busy; all other status bits read zero
// - Timeout defaults to ten seconds, adjustable
module gpib_block_talker_transmit #(
   parameter int COUNT_W = 15, // Byte count width
   parameter logic [31:0] TIMEOUT_CYCLES = `XMT_TIMEOUT_S * `XMT_CLK_HZ / 1 // Default handshake timeout
) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Talker addressed state from the bus front end
   input wire logic i_talker_addressed,
   // Packed word source
   output logic o_mem_req,
   output logic [31:0] o_mem_addr,
   input wire logic i_mem_ack,
   input wire logic [15:0] i_mem_data,
   // GPIB source handshake, levels as asserted
   output logic [7:0] o_gpib_data,
   output logic o_gpib_dav,
   output logic o_gpib_eoi,
   input wire logic i_gpib_nrfd,
   input wire logic i_gpib_ndac,
   // Interrupt
   output logic o_irq
);
   import gpib_xmit_pkg::*;

   // ***************************************************
   // Decode helpers
   // ***************************************************
   // Index of a terminator definition register, or 3'h4 if none
   function automatic logic [2:0] term_slot(input logic [7:0] addr);
      logic [7:0] rel;
      rel = addr - `XMT_OFS_TERM0;
      if (addr >= `XMT_OFS_TERM0 && addr < `XMT_OFS_TIMEOUT && rel[1:0] == 2'h0) begin
         term_slot = {1'b0, rel[3:2]};
      end else begin
         term_slot = 3'h4;
      end
   endfunction : term_slot

   // Default terminator for an index
   function automatic term_def_t term_default(input int idx);
      case (idx)
         0: term_default = `XMT_TERM_DEF0;
         1: term_default = `XMT_TERM_DEF1;
         2: term_default = `XMT_TERM_DEF2;
         default: term_default = `XMT_TERM_DEF3;
      endcase
   endfunction : term_default

   // ***************************************************
   // Register group state
   // ***************************************************
   logic [7:0] ctrl_ff, nxt_ctrl; // Transfer control byte
   logic [COUNT_W-1:0] count_ff, nxt_count; // Requested byte count
   logic [31:0] base_ff, nxt_base; // Word address of first word
   logic [31:0] tmo_ff, nxt_tmo; // Timeout in cycles
   term_def_t term_ff [4]; // Terminator definitions
   term_def_t nxt_term [4];
   logic [2:0] irq_stat_ff, nxt_irq_stat; // Sticky events
   logic [2:0] irq_en_ff, nxt_irq_en; // Event enables
   logic [31:0] prdata_ff, nxt_prdata; // Read data latched in setup
   logic slverr_ff, nxt_slverr; // Unmapped address flag

   // Engine state
   xmit_state_t state_ff, nxt_state;
   logic [COUNT_W-1:0] left_ff, nxt_left; // Data bytes still to send
   logic odd_ff, nxt_odd; // Next data byte is upper half
   logic [15:0] word_ff, nxt_word; // Current packed word
   logic [31:0] addr_ff, nxt_addr; // Next word address
   logic [1:0] term_pos_ff, nxt_term_pos; // Terminator chars already sent
   logic last_ff, nxt_last; // Byte on bus is the final one
   logic [31:0] timer_ff, nxt_timer; // Handshake wait counter
   logic [7:0] status_ff, nxt_status; // Returned status byte
   logic [7:0] data_ff, nxt_data;
   logic dav_ff, nxt_dav;
   logic eoi_ff, nxt_eoi;
   logic [2:0] evt_ff, nxt_evt; // One-cycle event pulses

   logic wr_en; // Write takes effect this edge
   logic setup; // Setup phase of any access
   logic start; // Start strobe from software
   logic [2:0] wslot; // Terminator slot addressed
   logic [2:0] rslot;
   logic mapped; // Address hits a register
   logic [1:0] sel_idx; // Selected terminator index
   term_def_t sel_term;
   logic timed_out;

   assign wr_en = i_psel && i_penable && i_pwrite;
   assign setup = i_psel && !i_penable;
   assign wslot = term_slot(i_paddr);
   assign rslot = wslot;
   assign start = wr_en && (i_paddr == `XMT_OFS_CMD) && i_pwdata[0];
   // Only bits 6:5 pick the terminator; 4:1 reach nothing
   assign sel_idx = {ctrl_ff[`XMT_CTRL_IDX_HI], ctrl_ff[`XMT_CTRL_IDX_LO]};
   assign sel_term = term_ff[sel_idx];
   assign timed_out = (timer_ff >= tmo_ff);

   // Zero wait states; read data was captured in setup
   assign o_pready = 1'b1;
   assign o_prdata = prdata_ff;
   assign o_pslverr = slverr_ff && i_psel && i_penable;

   // ***************************************************
   // Register group next values
   // ***************************************************
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_count = count_ff;
      nxt_base = base_ff;
      nxt_tmo = tmo_ff;
      nxt_irq_en = irq_en_ff;
      nxt_prdata = prdata_ff;
      nxt_slverr = slverr_ff;
      for (int i = 0; i < 4; i++) begin
         nxt_term[i] = term_ff[i];
      end
      mapped = 1'b1;
      // Read mux, evaluated in the setup cycle
      case (i_paddr)
         `XMT_OFS_CMD: nxt_prdata = {31'h0, state_ff != ST_IDLE};
         `XMT_OFS_CTRL: nxt_prdata = {24'h0, ctrl_ff};
         `XMT_OFS_COUNT: nxt_prdata = {{(32 - COUNT_W){1'b0}}, count_ff};
         `XMT_OFS_BASE: nxt_prdata = base_ff;
         `XMT_OFS_STATUS: nxt_prdata = {23'h0, state_ff != ST_IDLE, status_ff};
         `XMT_OFS_TIMEOUT: nxt_prdata = tmo_ff;
         `XMT_OFS_IRQ_STAT: nxt_prdata = {29'h0, irq_stat_ff};
         `XMT_OFS_IRQ_EN: nxt_prdata = {29'h0, irq_en_ff};
         `XMT_OFS_IRQ_CLR: nxt_prdata = 32'h0;
         default: begin
            // Terminator slots, otherwise unmapped
            if (rslot[2]) begin
               mapped = 1'b0;
               nxt_prdata = 32'h0;
            end else begin
               nxt_prdata = {15'h0, term_ff[rslot[1:0]]};
            end
         end
      endcase
      if (setup) begin
         nxt_slverr = !mapped;
      end else begin
         nxt_prdata = prdata_ff;
      end
      // Writes; parameters are locked while a transfer runs
      if (wr_en && state_ff == ST_IDLE) begin
         case (i_paddr)
            `XMT_OFS_CTRL: nxt_ctrl = i_pwdata[7:0];
            `XMT_OFS_COUNT: nxt_count = i_pwdata[COUNT_W-1:0];
            `XMT_OFS_BASE: nxt_base = i_pwdata;
            `XMT_OFS_TIMEOUT: nxt_tmo = i_pwdata;
            default: begin
               if (!wslot[2]) begin
                  nxt_term[wslot[1:0]] = i_pwdata[16:0];
               end
            end
         endcase
      end
      if (wr_en && i_paddr == `XMT_OFS_IRQ_EN) begin
         nxt_irq_en = i_pwdata[2:0];
      end
      // Set wins over a clear in the same cycle
      nxt_irq_stat = irq_stat_ff;
      if (wr_en && i_paddr == `XMT_OFS_IRQ_CLR) begin
         nxt_irq_stat = irq_stat_ff & ~i_pwdata[2:0];
      end
      nxt_irq_stat = nxt_irq_stat | evt_ff;
   end

   // ***************************************************
   // Register group flops
   // ***************************************************
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl_ff <= 8'h00;
         count_ff <= '0;
         base_ff <= 32'h0;
         tmo_ff <= TIMEOUT_CYCLES;
         for (int i = 0; i < 4; i++) begin
            term_ff[i] <= term_default(i);
         end
         irq_stat_ff <= 3'h0;
         irq_en_ff <= 3'h0;
         prdata_ff <= 32'h0;
         slverr_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         count_ff <= nxt_count;
         base_ff <= nxt_base;
         tmo_ff <= nxt_tmo;
         for (int i = 0; i < 4; i++) begin
            term_ff[i] <= nxt_term[i];
         end
         irq_stat_ff <= nxt_irq_stat;
         irq_en_ff <= nxt_irq_en;
         prdata_ff <= nxt_prdata;
         slverr_ff <= nxt_slverr;
      end
   end

   assign o_irq = |(irq_stat_ff & irq_en_ff);

   // ***************************************************
   // Transfer engine next values
   // ***************************************************
   always_comb begin
      nxt_state = state_ff;
      nxt_left = left_ff;
      nxt_odd = odd_ff;
      nxt_word = word_ff;
      nxt_addr = addr_ff;
      nxt_term_pos = term_pos_ff;
      nxt_last = last_ff;
      nxt_timer = timer_ff;
      nxt_status = status_ff;
      nxt_data = data_ff;
      nxt_dav = dav_ff;
      nxt_eoi = eoi_ff;
      nxt_evt = 3'h0;
      case (state_ff)
         ST_IDLE: begin
            if (start) begin
               // Fresh status; only TIMEOUT_ERROR_FLAG and NT can ever be set
               nxt_status = 8'h00;
               nxt_left = count_ff;
               nxt_odd = 1'b0;
               nxt_addr = base_ff;
               nxt_term_pos = 2'h0;
               if (!i_talker_addressed) begin
                  // Refuse outright, bus untouched
                  nxt_status[`XMT_STAT_NT] = 1'b1;
                  nxt_evt[`XMT_IRQ_NT] = 1'b1;
                  nxt_evt[`XMT_IRQ_DONE] = 1'b1;
               end else begin
                  nxt_state = ST_LOAD;
               end
            end
         end
         ST_LOAD: begin
            nxt_timer = 32'h0;
            if (left_ff != '0) begin
               // Final data byte only if nothing is appended
               nxt_last = (left_ff == COUNT_W'(1)) && !ctrl_ff[`XMT_CTRL_APPEND];
               if (!odd_ff) begin
                  nxt_state = ST_FETCH;
               end else begin
                  nxt_data = word_ff[15:8];
                  nxt_state = ST_WAIT_RFD;
               end
            end else if (ctrl_ff[`XMT_CTRL_APPEND]
                         && (term_pos_ff == 2'h0 || (term_pos_ff == 2'h1 && sel_term[`XMT_TERM_TWO]))) begin
               // Terminator characters follow the data; the count stops a second char repeating
               nxt_data = term_pos_ff[0] ? sel_term[15:8] : sel_term[7:0];
               nxt_last = term_pos_ff[0] || !sel_term[`XMT_TERM_TWO];
               nxt_state = ST_WAIT_RFD;
            end else begin
               nxt_evt[`XMT_IRQ_DONE] = 1'b1;
               nxt_state = ST_IDLE;
            end
         end
         ST_FETCH: begin
            if (i_mem_ack) begin
               // Low half goes first
               nxt_word = i_mem_data;
               nxt_data = i_mem_data[7:0];
               nxt_addr = addr_ff + 32'h1;
               nxt_state = ST_WAIT_RFD;
            end
         end
         ST_WAIT_RFD: begin
            nxt_timer = timer_ff + 32'h1;
            if (!i_gpib_nrfd) begin
               nxt_dav = 1'b1;
               // EOI only with the final byte and only if asked
               nxt_eoi = last_ff && ctrl_ff[`XMT_CTRL_EOI];
               nxt_timer = 32'h0;
               nxt_state = ST_WAIT_ACC;
            end else if (timed_out) begin
               nxt_status[`XMT_STAT_TMO] = 1'b1;
               nxt_evt = 3'b011;
               nxt_state = ST_IDLE;
            end
         end
         ST_WAIT_ACC: begin
            nxt_timer = timer_ff + 32'h1;
            if (!i_gpib_ndac) begin
               // Byte accepted; advance the counters
               nxt_dav = 1'b0;
               nxt_eoi = 1'b0;
               if (left_ff != '0) begin
                  nxt_left = left_ff - COUNT_W'(1);
                  nxt_odd = !odd_ff;
               end else begin
                  nxt_term_pos = term_pos_ff + 2'h1;
               end
               nxt_state = ST_LOAD;
            end else if (timed_out) begin
               // Abort: drop DAV and EOI so the bus is released
               nxt_dav = 1'b0;
               nxt_eoi = 1'b0;
               nxt_status[`XMT_STAT_TMO] = 1'b1;
               nxt_evt = 3'b011;
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
            nxt_dav = 1'b0;
            nxt_eoi = 1'b0;
         end
      endcase
   end

   // ***************************************************
   // Transfer engine flops
   // ***************************************************
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_ff <= ST_IDLE;
         left_ff <= '0;
         odd_ff <= 1'b0;
         word_ff <= 16'h0;
         addr_ff <= 32'h0;
         term_pos_ff <= 2'h0;
         last_ff <= 1'b0;
         timer_ff <= 32'h0;
         status_ff <= 8'h00;
         data_ff <= 8'h00;
         dav_ff <= 1'b0;
         eoi_ff <= 1'b0;
         evt_ff <= 3'h0;
      end else begin
         state_ff <= nxt_state;
         left_ff <= nxt_left;
         odd_ff <= nxt_odd;
         word_ff <= nxt_word;
         addr_ff <= nxt_addr;
         term_pos_ff <= nxt_term_pos;
         last_ff <= nxt_last;
         timer_ff <= nxt_timer;
         status_ff <= nxt_status;
         data_ff <= nxt_data;
         dav_ff <= nxt_dav;
         eoi_ff <= nxt_eoi;
         evt_ff <= nxt_evt;
      end
   end

   // Request is a handshake output; address comes from a flop
   assign o_mem_req = (state_ff == ST_FETCH);
   assign o_mem_addr = addr_ff;
   assign o_gpib_data = data_ff;
   assign o_gpib_dav = dav_ff;
   assign o_gpib_eoi = eoi_ff;

endmodule : gpib_block_talker_transmit

// >>> gpib_far_side_model.sv
`timescale 1ns/1ps
// ***************************************************
// Word source and one GPIB listener
// ***************************************************
module gpib_far_side_model (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_stall, // Holds not-ready high
   input wire logic i_req,
   input wire logic [31:0] i_addr,
   output logic o_ack,
   output logic [15:0] o_data,
   input wire logic i_dav,
   input wire logic [7:0] i_byte,
   input wire logic i_eoi,
   output logic o_nrfd,
   output logic o_ndac
);
   logic [7:0] got_b [$]; // Bytes accepted
   logic got_e [$]; // End flag per byte
   // Word source: one-cycle ack, data churns when idle
   always @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_ack <= 1'b0;
         o_data <= 16'h0;
      end else begin
         o_ack <= i_req && !o_ack;
         o_data <= (i_req && !o_ack) ? {~i_addr[7:0], i_addr[7:0]} : ~o_data;
      end
   end
   // Listener: accept once per valid, rearm on release
   always @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_nrfd <= 1'b1;
         o_ndac <= 1'b1;
      end else if (i_dav && o_ndac && !i_stall) begin
         got_b.push_back(i_byte);
         got_e.push_back(i_eoi);
         o_ndac <= 1'b0;
         o_nrfd <= 1'b1;
      end else if (!i_dav) begin
         o_ndac <= 1'b1;
         o_nrfd <= i_stall; // Stalling never gets ready
      end
   end
endmodule : gpib_far_side_model

// >>> gpib_xmit_consts.svh
`ifndef GPIB_XMIT_CONSTS_SVH
`define GPIB_XMIT_CONSTS_SVH

// ***************************************************
// Register byte offsets
// ***************************************************
`define XMT_OFS_CMD 8'h00
`define XMT_OFS_CTRL 8'h04
`define XMT_OFS_COUNT 8'h08
`define XMT_OFS_BASE 8'h0c
`define XMT_OFS_STATUS 8'h10
`define XMT_OFS_TERM0 8'h14
`define XMT_OFS_TIMEOUT 8'h24
`define XMT_OFS_IRQ_STAT 8'h28
`define XMT_OFS_IRQ_EN 8'h2c
`define XMT_OFS_IRQ_CLR 8'h30

// ***************************************************
// Control byte fields
// ***************************************************
`define XMT_CTRL_EOI 0
`define XMT_CTRL_IDX_LO 5
`define XMT_CTRL_IDX_HI 6
`define XMT_CTRL_APPEND 7

// ***************************************************
// Status byte fields
// ***************************************************
`define XMT_STAT_NT 1
`define XMT_STAT_TMO 3
`define XMT_STAT_BUSY 8

// ***************************************************
// Interrupt event bits
// ***************************************************
`define XMT_IRQ_DONE 0
`define XMT_IRQ_TMO 1
`define XMT_IRQ_NT 2

// ***************************************************
// Terminator definition layout and defaults
// ***************************************************
`define XMT_TERM_TWO 16
`define XMT_CHAR_LF 8'h0a
`define XMT_CHAR_CR 8'h0d
`define XMT_TERM_DEF0 17'h0000a
`define XMT_TERM_DEF1 17'h10a0d
`define XMT_TERM_DEF2 17'h0000d
`define XMT_TERM_DEF3 17'h10d0a

// ***************************************************
// Timing
// ***************************************************
`define XMT_TIMEOUT_S 10
`define XMT_CLK_HZ 100000000

`endif

// >>> gpib_xmit_pkg.sv
package gpib_xmit_pkg;

   // ***************************************************
   // Transfer engine states
   // ***************************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, // Waiting for a start
      ST_LOAD = 3'b001, // Pick the next byte or finish
      ST_FETCH = 3'b010, // Read one packed word
      ST_WAIT_RFD = 3'b011, // Wait for listeners ready
      ST_WAIT_ACC = 3'b100 // Data valid, wait for accept
   } xmit_state_t;

   typedef logic [16:0] term_def_t; // Two chars plus length flag

endpackage : gpib_xmit_pkg

// >>> gpib_xmit_properties.sv
`timescale 1ns/1ps
`include "gpib_xmit_consts.svh"
// ***************************************************
// Port checker
// ***************************************************
module gpib_xmit_properties (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic i_talker_addressed,
   input wire logic o_mem_req,
   input wire logic [31:0] o_mem_addr,
   input wire logic i_mem_ack,
   input wire logic [15:0] i_mem_data,
   input wire logic [7:0] o_gpib_data,
   input wire logic o_gpib_dav,
   input wire logic o_gpib_eoi,
   input wire logic i_gpib_nrfd,
   input wire logic i_gpib_ndac,
   input wire logic o_irq
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   // Steps of a bus access and of a refused start
   sequence apb_access_s;
      i_psel && i_penable;
   endsequence
   sequence nt_start_s;
      apb_access_s ##0 (i_pwrite && i_paddr == `XMT_OFS_CMD && i_pwdata[0] && !i_talker_addressed);
   endsequence
   sequence bus_quiet_s;
      (!o_gpib_dav && !o_gpib_eoi && !o_mem_req) [*8];
   endsequence
   eoi_with_dav_a: assert property (o_gpib_eoi |-> o_gpib_dav)
      else $error("end flag without data valid");
   eoi_at_rise_a: assert property ($rose(o_gpib_eoi) |-> $rose(o_gpib_dav))
      else $error("end flag raised mid byte");
   dav_needs_rfd_a: assert property ($rose(o_gpib_dav) |-> $past(i_gpib_nrfd) == 1'b0)
      else $error("data valid before ready");
   data_stable_a: assert property (o_gpib_dav && $past(o_gpib_dav) |-> $stable(o_gpib_data))
      else $error("byte changed while valid");
   dav_release_a: assert property (o_gpib_dav && !i_gpib_ndac |=> !o_gpib_dav)
      else $error("data valid held after accept");
   fetch_hold_a: assert property (o_mem_req && !i_mem_ack |=> o_mem_req)
      else $error("word request dropped early");
   not_talker_a: assert property (nt_start_s |=> bus_quiet_s)
      else $error("bus activity while not talker");
   status_zero_a: assert property (apb_access_s ##0 (!i_pwrite && i_paddr == `XMT_OFS_STATUS)
      |-> (o_prdata[7:0] & 8'hf5) == 8'h00)
      else $error("status spare bits set");
endmodule : gpib_xmit_properties

bind gpib_block_talker_transmit gpib_xmit_properties props_i (.*);

// >>> tb.sv
`timescale 1ns/1ps
`include "gpib_xmit_consts.svh"
module tb;
   import gpib_xmit_pkg::*;
   // ***************************************************
   // Stimulus and observed signals
   // ***************************************************
   logic i_core_clk = 1'b0, i_nrst = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [7:0] i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0;
   logic i_talker_addressed = 1'b0, stall = 1'b0; // Stall makes the listener hang
   logic [31:0] o_prdata, o_mem_addr, rdata;
   logic o_pready, o_pslverr, o_mem_req, i_mem_ack, o_gpib_dav, o_gpib_eoi, i_gpib_nrfd, i_gpib_ndac, o_irq, rerr;
   logic [15:0] i_mem_data;
   logic [7:0] o_gpib_data;
   int mismatches = 0, compares = 0;
   term_def_t term_tb [4] = '{`XMT_TERM_DEF0, `XMT_TERM_DEF1, `XMT_TERM_DEF2, `XMT_TERM_DEF3};
   gpib_block_talker_transmit gpib_block_talker_transmit_i (.*);
   gpib_far_side_model gpib_far_side_model_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_stall(stall),
      .i_req(o_mem_req), .i_addr(o_mem_addr), .o_ack(i_mem_ack), .o_data(i_mem_data), .i_dav(o_gpib_dav),
      .i_byte(o_gpib_data), .i_eoi(o_gpib_eoi), .o_nrfd(i_gpib_nrfd), .o_ndac(i_gpib_ndac));
   // Clock
   initial begin
      forever #5 i_core_clk = ~i_core_clk;
   end
   // ***************************************************
   // Tasks
   // ***************************************************
   task finish_test;
      $display("mismatches=%0d compares=%0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // One APB transfer; waits on pready, takes data at that edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_core_clk);
      i_penable <= 1'b1;
      do @(posedge i_core_clk); while (o_pready !== 1'b1);
      rdata = o_prdata;
      rerr = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rd
   // Block send from word base 0x20, then compare status and, unless a timeout is expected, bus bytes
   task xfer(input logic [7:0] ctrl, input logic [14:0] cnt, input logic [31:0] st);
      logic [7:0] eb [$];
      logic [31:0] w;
      term_def_t t;
      int n;
      eb = {};
      for (int i = 0; i < cnt; i++) begin
         w = 32'h20 + i / 2;
         eb.push_back(i[0] ? ~w[7:0] : w[7:0]);
      end
      if (ctrl[7]) begin
         t = term_tb[ctrl[6:5]];
         eb.push_back(t[7:0]);
         if (t[16]) eb.push_back(t[15:8]);
      end
      if (st[1]) eb = {}; // Refused start sends nothing
      gpib_far_side_model_i.got_b = {};
      gpib_far_side_model_i.got_e = {};
      wr(`XMT_OFS_CTRL, {24'h0, ctrl});
      wr(`XMT_OFS_COUNT, {17'h0, cnt});
      wr(`XMT_OFS_BASE, 32'h20);
      wr(`XMT_OFS_CMD, 32'h1);
      n = 0;
      rd(`XMT_OFS_STATUS);
      while (rdata[8] === 1'b1 && n < 300) begin
         rd(`XMT_OFS_STATUS);
         n++;
      end
      chk(rdata, st);
      if (st[3] === 1'b0) begin
         chk(gpib_far_side_model_i.got_b.size(), eb.size());
         foreach (eb[i]) begin
            chk({24'h0, gpib_far_side_model_i.got_b[i]}, {24'h0, eb[i]});
            chk({31'h0, gpib_far_side_model_i.got_e[i]}, {31'h0, ctrl[0] && i == eb.size() - 1});
         end
      end
   endtask : xfer
   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      repeat (12) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         rd(8'h14 + 8'(4 * k));
         chk(rdata, {15'h0, term_tb[k]});
      end
      rd(`XMT_OFS_TIMEOUT);
      chk(rdata, 32'd1000000000);
      rd(`XMT_OFS_STATUS);
      chk(rdata, 32'h0);
      rd(8'h40);
      chk({31'h0, rerr}, 32'h1);
      chk(rdata, 32'h0);
      wr(`XMT_OFS_IRQ_EN, 32'h7);
      xfer(8'h81, 15'd2, 32'h02);
      chk({31'h0, o_irq}, 32'h1);
      rd(`XMT_OFS_IRQ_STAT);
      chk(rdata, 32'h5);
      wr(`XMT_OFS_IRQ_CLR, 32'h7);
      rd(`XMT_OFS_IRQ_STAT);
      chk(rdata, 32'h0);
      chk({31'h0, o_irq}, 32'h0);
      // Masked completion, ignored control bits, odd count
      i_talker_addressed <= 1'b1;
      wr(`XMT_OFS_IRQ_EN, 32'h0);
      xfer(8'h1f, 15'd3, 32'h0);
      rd(`XMT_OFS_IRQ_STAT);
      chk(rdata, 32'h1);
      chk({31'h0, o_irq}, 32'h0);
      wr(`XMT_OFS_IRQ_EN, 32'h7);
      rd(`XMT_OFS_IRQ_EN);
      chk(rdata, 32'h7);
      chk({31'h0, o_irq}, 32'h1);
      wr(`XMT_OFS_IRQ_CLR, 32'h7);
      // Short timeout against a hung listener
      wr(`XMT_OFS_TIMEOUT, 32'd50);
      stall <= 1'b1;
      xfer(8'h00, 15'd2, 32'h08);
      stall <= 1'b0;
      rd(`XMT_OFS_IRQ_STAT);
      chk(rdata, 32'h3);
      wr(`XMT_OFS_IRQ_CLR, 32'h7);
      // Every terminator index, then a redefined one
      for (int k = 0; k < 4; k++) begin
         xfer({1'b1, 2'(k), 5'h01}, 15'd2, 32'h0);
      end
      wr(8'h1c, 32'h00014142);
      term_tb[2] = 17'h14142;
      xfer(8'hc0, 15'd1, 32'h0);
      xfer(8'h40, 15'd4, 32'h0);
      finish_test;
   end
   // Watchdog
   initial begin
      // Tests need well under 10,000 cycles; this stops a hang at 30,000
      #300us;
      mismatches++;
      finish_test;
   end
endmodule : tb
